/* File: rsh_pkg.sv */
// shared map, flag positions, error codes and bus constants for the station link
package rsh_pkg;

   // word areas of the four-node layout, counted in link words from the start address
   localparam int unsigned BIT_WORDS = 7;
   localparam int unsigned DATA_WORDS = 16;
   localparam logic [5:0] BIT_IN_BASE = 6'h00;
   localparam logic [5:0] STATUS_OFS = 6'h07;
   localparam logic [5:0] BIT_OUT_BASE = 6'h0A;
   localparam logic [5:0] REQUEST_OFS = 6'h11;
   localparam logic [5:0] RET_BASE = 6'h14;
   localparam logic [5:0] CMD_BASE = 6'h24;
   localparam logic [5:0] LAST_WORD = 6'h33;

   // status word bits, driven by the station
   localparam int unsigned ST_DISP_DONE = 0;
   localparam int unsigned ST_TOUCH_DONE = 5;
   localparam int unsigned ST_TAG_REQ = 7;
   localparam int unsigned ST_INIT_DONE = 9;
   localparam int unsigned ST_ERROR = 10;
   localparam int unsigned ST_READY = 11;

   // request word bits, driven by the master
   localparam int unsigned RQ_DISPLAY = 0;
   localparam int unsigned RQ_MONITOR = 1;
   localparam int unsigned RQ_PERIODIC = 2;
   localparam int unsigned RQ_INIT = 9;
   localparam int unsigned RQ_ERR_RESET = 10;
   localparam logic [15:0] RQ_MASK = 16'h0607;

   // reset values
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [7:0] CODE_NONE = 8'h00;

   // error codes reported in the first return word
   localparam logic [7:0] ERR_POINT_RANGE = 8'h01;
   localparam logic [7:0] ERR_ADDR_RANGE = 8'h02;
   localparam logic [7:0] ERR_UNDEF_CMD = 8'h03;
   localparam logic [7:0] ERR_INIT_CMD = 8'h04;
   localparam logic [7:0] ERR_INIT_MODE = 8'h05;
   localparam logic [7:0] ERR_NO_MONITOR = 8'h06;
   localparam logic [7:0] ERR_NO_PERIODIC = 8'h07;
   localparam logic [7:0] ERR_PROTECTED = 8'h08;
   localparam logic [7:0] ERR_OFFLINE = 8'h09;
   localparam logic [7:0] ERR_HW_SILENT = 8'h14;
   localparam logic [7:0] ERR_HW_FAULT = 8'h15;
   localparam logic [7:0] ERR_SWITCH_LAST = 8'h19;
   localparam logic [7:0] ERR_CRC = 8'h1A;
   localparam logic [7:0] ERR_TIMEOUT = 8'h1B;
   localparam logic [7:0] ERR_CARRIER0 = 8'h1C;
   localparam logic [7:0] ERR_CARRIER1 = 8'h1D;
   localparam logic [7:0] ERR_TRANSFER = 8'h1E;
   localparam logic [7:0] ERR_NUM_EITHER = 8'h1F;
   localparam logic [7:0] ERR_NUM_BITS = 8'h20;
   localparam logic [7:0] ERR_NUM_WORDS = 8'h21;

   // apb data width and zero answer
   localparam logic [31:0] APB_ZERO = 32'h0000_0000;

   // codes 01..09, 14..19 and 1a..21 are defined, everything else is not
   function automatic logic rsh_code_ok(input logic [7:0] code);
      logic ok;
      ok = 1'b0;
      if (code >= ERR_POINT_RANGE && code <= ERR_OFFLINE) begin
         ok = 1'b1; // [R13] [R14] [R15] [R16]
      end
      if (code >= ERR_HW_SILENT && code <= ERR_SWITCH_LAST) begin
         ok = 1'b1; // [R17]
      end
      if (code >= ERR_CRC && code <= ERR_TRANSFER) begin
         ok = 1'b1; // [R18]
      end
      if (code >= ERR_NUM_EITHER && code <= ERR_NUM_WORDS) begin
         ok = 1'b1; // [R19]
      end
      return ok;
   endfunction : rsh_code_ok

endpackage : rsh_pkg

/* File: rsh_link_if.sv */
`timescale 1ns/1ps
// link memory shared between the master and the station, one signal per word area
interface rsh_link_if;
   // station to master
   logic [6:0][15:0] bit_in;
   logic [15:0] status;
   logic [15:0][15:0] ret;
   // master to station
   logic [6:0][15:0] bit_out;
   logic [15:0] request;
   logic [15:0][15:0] cmd;

   modport dev (
      output bit_in,
      output status,
      output ret,
      input bit_out,
      input request,
      input cmd
   );

   modport mst (
      input bit_in,
      input status,
      input ret,
      output bit_out,
      output request,
      output cmd
   );
endinterface : rsh_link_if

/* File: rsh_station.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
// Overview of operation
// R1: seven bit-input words at link words 0..6
// R2: status word: display, touch, ready flags
// R3: status bit 7 asks tag code readout
// R4: status bit 9 marks initial setting complete
// R5: master keeps seven bit-output words 10..16
// R6: request bit0 display, bit1 monitoring
// R7: request bit2 asks periodic write
// R8: request bit9 asks initial data setting
// R9: request bit10 asks error clear
// R10: sixteen return words at 20..35
// R11: sixteen command words at 36..51
// R12: error: code in return, error+display flags
// R13: codes 01 point, 02 address, 03 command
// R14: codes 04 initial command, 05 mode
// R15: codes 06 monitor, 07 periodic unregistered
// R16: codes 08 protected area, 09 offline
// R17: codes 14 silent, 15 fault, 16-19 switches
// R18: codes 1a-1e link faults
// R19: codes 1f-21 numerical errors
// R20: completion clears after request withdrawn
// R21: error reset clears flag and code
// R22: gap words and unlisted bits read zero

// station end: owns the bit inputs, the status word and the return words
module rsh_station (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link side
   rsh_link_if.dev link,
   // panel bit inputs and monitor data
   input wire logic [6:0][15:0] user_bits,
   input wire logic [15:0][15:0] user_ret,
   // panel events
   input wire logic disp_done,
   input wire logic touch_on,
   input wire logic tag_req,
   input wire logic init_done,
   input wire logic remote_ready,
   // panel error report
   input wire logic err_valid,
   input wire logic [7:0] err_code,
   // copies of what the master wrote
   output logic [6:0][15:0] user_bit_out,
   output logic [15:0] user_request,
   output logic [15:0][15:0] user_cmd,
   // error state seen by the panel
   output logic err_active,
   output logic [7:0] err_code_out
);

   logic [6:0][15:0] bit_in_reg;
   logic [15:0][15:0] ret_reg;
   logic [15:0] status_reg;
   logic [15:0] status_next;
   logic disp_done_reg;
   logic init_done_reg;
   logic err_flag_reg;
   logic [7:0] err_code_reg;
   logic [6:0][15:0] bit_out_reg;
   logic [15:0] request_reg;
   logic [15:0][15:0] cmd_reg;
   logic err_take;
   logic disp_withdrawn;
   logic err_clear;
   logic init_req;

   // only defined codes raise the error, an unknown code would hide the real one
   assign err_take = err_valid && rsh_pkg::rsh_code_ok(err_code); // [R13] [R14] [R15] [R16] [R17] [R18] [R19]

   // both display-side requests down means the master has seen the completion
   assign disp_withdrawn = !link.request[rsh_pkg::RQ_DISPLAY] && !link.request[rsh_pkg::RQ_MONITOR];

   // request bits as named signals; the error reset bit is read by two processes
   assign err_clear = link.request[rsh_pkg::RQ_ERR_RESET]; // [R9]
   assign init_req = link.request[rsh_pkg::RQ_INIT]; // [R8]

   // error code as a return word; the upper byte is always zero
   function automatic logic [15:0] rsh_code_word(input logic [7:0] code);
      return {8'h00, code};
   endfunction : rsh_code_word

   // bit inputs are sampled once a clock and held for the master
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_in_reg <= '0;
      end else begin
         bit_in_reg <= user_bits; // [R1]
      end
   end

   // display complete: set by the panel or by an error, dropped when the request falls
   // an error holds display done up until the error itself is cleared
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disp_done_reg <= 1'b0;
      end else begin
         if (err_take) begin
            disp_done_reg <= 1'b1; // [R12]
         end else if (disp_done) begin
            disp_done_reg <= 1'b1; // [R2]
         end else if (disp_withdrawn && !err_flag_reg) begin
            disp_done_reg <= 1'b0; // [R20]
         end
      end
   end

   // initial data setting complete follows the init request handshake
   // a pulse without the request is dropped, so a stale event cannot complete a later request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_done_reg <= 1'b0;
      end else begin
         if (init_done && init_req) begin
            init_done_reg <= 1'b1; // [R4]
         end else if (!init_req) begin
            init_done_reg <= 1'b0; // [R20]
         end
      end
   end

   // error flag and code; a new error in the reset cycle wins over the clear
   // limitation: undefined codes are dropped here and never reach the master
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_flag_reg <= 1'b0;
         err_code_reg <= rsh_pkg::CODE_NONE;
      end else begin
         if (err_take) begin
            err_flag_reg <= 1'b1; // [R12]
            err_code_reg <= err_code; // [R12]
         end else if (err_clear) begin
            err_flag_reg <= 1'b0; // [R21]
            err_code_reg <= rsh_pkg::CODE_NONE; // [R21]
         end
      end
   end

   // assemble the status word; unlisted bits stay zero
   always_comb begin
      status_next = rsh_pkg::WORD_RESET; // [R22]
      status_next[rsh_pkg::ST_DISP_DONE] = disp_done_reg; // [R2]
      status_next[rsh_pkg::ST_TOUCH_DONE] = touch_on; // [R2]
      status_next[rsh_pkg::ST_TAG_REQ] = tag_req; // [R3]
      status_next[rsh_pkg::ST_INIT_DONE] = init_done_reg; // [R4]
      status_next[rsh_pkg::ST_ERROR] = err_flag_reg; // [R12]
      status_next[rsh_pkg::ST_READY] = remote_ready; // [R2]
   end

   // the status word itself is a register so the link never sees a glitch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= rsh_pkg::WORD_RESET;
      end else begin
         status_reg <= status_next; // [R2]
      end
   end

   // return words: monitor data, with the error code in word 0 while an error stands
   // the code is written in the same edge as the flag so the master never sees
   // the flag with stale data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ret_reg <= '0;
      end else begin
         ret_reg <= user_ret; // [R10]
         if (err_take) begin
            ret_reg[0] <= rsh_code_word(err_code); // [R12]
         end else if (err_flag_reg && !err_clear) begin
            ret_reg[0] <= rsh_code_word(err_code_reg); // [R12]
         end
      end
   end

   // register copies of the master's words for the panel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_out_reg <= '0;
         cmd_reg <= '0;
      end else begin
         bit_out_reg <= link.bit_out; // [R5]
         cmd_reg <= link.cmd; // [R11]
      end
   end

   // request copy keeps only the defined bits
   // the panel sees the request one clock after the link, like the other copies
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         request_reg <= rsh_pkg::WORD_RESET;
      end else begin
         request_reg <= link.request & rsh_pkg::RQ_MASK; // [R6] [R7] [R8] [R9] [R22]
      end
   end

   // link side outputs
   assign link.bit_in = bit_in_reg;
   assign link.status = status_reg;
   assign link.ret = ret_reg;

   // panel side outputs
   assign user_bit_out = bit_out_reg;
   assign user_request = request_reg;
   assign user_cmd = cmd_reg;
   assign err_active = err_flag_reg;
   assign err_code_out = err_code_reg;

endmodule : rsh_station

/* File: rsh_master.sv */
`timescale 1ns/1ps
// master end: software drives the link words over apb and reads back the station's words
module rsh_master (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link side
   rsh_link_if.mst link
);

   logic [6:0][15:0] bit_out_reg;
   logic [15:0] request_reg;
   logic [15:0][15:0] cmd_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] rd_word;
   logic rd_ok;
   logic [5:0] word;
   logic wr_fire;

   // byte address is four times the link word index
   assign word = paddr[7:2];
   assign wr_fire = psel && penable && pready_reg && pwrite && !pslverr_reg;

   // true when the word index lies in [lo, hi]; shared by the read and write decode
   function automatic logic rsh_in_area(input logic [5:0] w, input logic [5:0] lo, input logic [5:0] hi);
      return (w >= lo) && (w <= hi);
   endfunction : rsh_in_area

   // read decode; gaps and reserved bits answer zero
   always_comb begin
      rd_word = rsh_pkg::APB_ZERO; // [R22]
      rd_ok = (word <= rsh_pkg::LAST_WORD) && (paddr[1:0] == 2'b00);
      if (word < rsh_pkg::STATUS_OFS) begin
         rd_word = {16'h0000, link.bit_in[3'(word)]}; // [R1]
      end else if (word == rsh_pkg::STATUS_OFS) begin
         rd_word = {16'h0000, link.status}; // [R2]
      end else if (rsh_in_area(word, rsh_pkg::BIT_OUT_BASE, rsh_pkg::REQUEST_OFS - 6'h01)) begin
         rd_word = {16'h0000, bit_out_reg[3'(word - rsh_pkg::BIT_OUT_BASE)]}; // [R5]
      end else if (word == rsh_pkg::REQUEST_OFS) begin
         rd_word = {16'h0000, request_reg}; // [R6]
      end else if (word >= rsh_pkg::RET_BASE && word < rsh_pkg::CMD_BASE) begin
         rd_word = {16'h0000, link.ret[4'(word - rsh_pkg::RET_BASE)]}; // [R10]
      end else if (rsh_in_area(word, rsh_pkg::CMD_BASE, rsh_pkg::LAST_WORD)) begin
         rd_word = {16'h0000, cmd_reg[4'(word - rsh_pkg::CMD_BASE)]}; // [R11]
      end
   end

   // answer is prepared in the setup cycle, so the access phase completes at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= rsh_pkg::APB_ZERO;
      end else begin
         pready_reg <= psel && !penable;
         pslverr_reg <= psel && !penable && !rd_ok;
         if (psel && !penable) begin
            prdata_reg <= (pwrite || !rd_ok) ? rsh_pkg::APB_ZERO : rd_word; // [R22]
         end
      end
   end

   // writable link words; station-owned words ignore writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_out_reg <= '0;
         request_reg <= rsh_pkg::WORD_RESET;
         cmd_reg <= '0;
      end else if (wr_fire) begin
         if (rsh_in_area(word, rsh_pkg::BIT_OUT_BASE, rsh_pkg::REQUEST_OFS - 6'h01)) begin
            bit_out_reg[3'(word - rsh_pkg::BIT_OUT_BASE)] <= pwdata[15:0]; // [R5]
         end else if (word == rsh_pkg::REQUEST_OFS) begin
            request_reg <= pwdata[15:0] & rsh_pkg::RQ_MASK; // [R6] [R7] [R8] [R9] [R22]
         end else if (rsh_in_area(word, rsh_pkg::CMD_BASE, rsh_pkg::LAST_WORD)) begin
            cmd_reg[4'(word - rsh_pkg::CMD_BASE)] <= pwdata[15:0]; // [R11]
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign link.bit_out = bit_out_reg;
   assign link.request = request_reg;
   assign link.cmd = cmd_reg;

endmodule : rsh_master

/* File: rsh_asserts.sv */
`timescale 1ns/1ps
// link word checks between the two ends
module rsh_asserts (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link words
   input wire logic [6:0][15:0] bit_in,
   input wire logic [15:0] status,
   input wire logic [15:0][15:0] ret,
   input wire logic [6:0][15:0] bit_out,
   input wire logic [15:0] request,
   input wire logic [15:0][15:0] cmd
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // unlisted flag bits stay low on both sides
   property p_st_rsvd; (status & 16'hF15E) == 16'h0000; endproperty
   property p_rq_rsvd; (request & 16'hF9F8) == 16'h0000; endproperty
   // an error shows with display done and a nonzero code, upper byte zero, in the first return word
   property p_err_disp; $rose(status[10]) |-> status[0]; endproperty
   property p_err_code; $rose(status[10]) |-> ret[0][15:8] == 8'h00 && ret[0][7:0] != 8'h00; endproperty
   property p_err_clr; status[10] && request[10] |-> ##[1:3] !status[10]; endproperty
   // completions stand while requested and drop soon after withdrawal
   property p_disp_hold; status[0] && (request[0] || request[1]) |=> status[0]; endproperty
   property p_disp_drop; status[0] && request[1:0] == 2'b00 && !status[10] |-> ##[1:3] !status[0]; endproperty
   property p_init_hold; status[9] && request[9] |=> status[9]; endproperty
   property p_init_drop; $fell(request[9]) |-> ##[1:3] !status[9]; endproperty
   property p_init_need; $rose(status[9]) |-> $past(request[9], 2); endproperty
   a_st_rsvd: assert property (p_st_rsvd) else $error("reserved status bit set");
   a_rq_rsvd: assert property (p_rq_rsvd) else $error("reserved request bit set");
   a_err_disp: assert property (p_err_disp) else $error("error without display done");
   a_err_code: assert property (p_err_code) else $error("bad error code word");
   a_err_clr: assert property (p_err_clr) else $error("error not cleared");
   a_disp_hold: assert property (p_disp_hold) else $error("display done dropped early");
   a_disp_drop: assert property (p_disp_drop) else $error("display done stuck");
   a_init_hold: assert property (p_init_hold) else $error("init done dropped early");
   a_init_drop: assert property (p_init_drop) else $error("init done stuck");
   a_init_need: assert property (p_init_need) else $error("init done without request");
   c_err: cover property ($rose(status[10]));
   c_init: cover property ($rose(status[9]));
   c_disp: cover property ($fell(status[0]));
endmodule : rsh_asserts

/* File: rsh_bench.sv */
`timescale 1ns/1ps
// apb software on the master end, panel inputs on the station end
module rsh_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ok;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [6:0][15:0] user_bits, ubo;
   logic [15:0][15:0] user_ret, ucmd;
   logic [15:0] ureq;
   logic disp_done, touch_on, tag_req, init_done, remote_ready, err_valid, err_active;
   logic [7:0] err_code, ecode;
   logic [7:0] odd [7] = '{8'h20, 8'h24, 8'h48, 8'h4C, 8'h1C, 8'hD0, 8'h02};
   int mismatches, total_checks;

   rsh_link_if link();
   rsh_master i_rsh_master (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
   rsh_station i_rsh_station (.pclk(pclk), .presetn(presetn), .link(link), .user_bits(user_bits),
      .user_ret(user_ret), .disp_done(disp_done), .touch_on(touch_on), .tag_req(tag_req), .init_done(init_done),
      .remote_ready(remote_ready), .err_valid(err_valid), .err_code(err_code), .user_bit_out(ubo),
      .user_request(ureq), .user_cmd(ucmd), .err_active(err_active), .err_code_out(ecode));
   rsh_asserts i_rsh_asserts (.pclk(pclk), .presetn(presetn), .bit_in(link.bit_in), .status(link.status),
      .ret(link.ret), .bit_out(link.bit_out), .request(link.request), .cmd(link.cmd));

   // clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one transfer; idle edges after it let the station settle before the next look
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      chk({31'h0, pslverr}, {31'h0, (a > 8'hCC) || (a[1:0] != 2'b00)});
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      apb(1'b0, a, 32'h0000_0000, r);
      chk(r, exp);
   endtask : rdc

   // one-cycle panel event: 0 display, 1 init, else error
   task automatic pls(input int s);
      case (s)
         0: disp_done <= 1'b1;
         1: init_done <= 1'b1;
         default: err_valid <= 1'b1;
      endcase
      @(posedge pclk);
      disp_done <= 1'b0;
      init_done <= 1'b0;
      err_valid <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : pls

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {disp_done, touch_on, tag_req, init_done, remote_ready, err_valid, err_code} = '0;
      for (int k = 0; k < 16; k++) begin
         user_ret[k] = 16'hD200 + 16'(k);
         if (k < 7) user_bits[k] = 16'hB100 + 16'(k);
      end
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(8'h1C, 32'h0000_0000);
      chk({24'h00_0000, ecode}, 32'h0000_0000);
      wr(8'h44, 32'hFFFF_FFFF);
      rdc(8'h44, 32'h0000_0607);
      chk({16'h0000, ureq}, 32'h0000_0607);
      wr(8'h44, 32'h0000_0000);
      // word areas both ways
      for (int k = 0; k < 16; k++) begin
         wr(8'h90 + 8'(4 * k), 32'hFFFF_C300 + 32'(k));
         rdc(8'h90 + 8'(4 * k), 32'h0000_C300 + 32'(k));
         chk({16'h0000, ucmd[k]}, 32'h0000_C300 + 32'(k));
         rdc(8'h50 + 8'(4 * k), 32'h0000_D200 + 32'(k));
         if (k < 7) begin
            wr(8'h28 + 8'(4 * k), 32'h0000_5A00 + 32'(k));
            chk({16'h0000, ubo[k]}, 32'h0000_5A00 + 32'(k));
            rdc(8'(4 * k), 32'h0000_B100 + 32'(k));
         end
      end
      // gaps, read-only status and refused addresses read zero
      foreach (odd[i]) begin
         wr(odd[i], 32'hFFFF_FFFF);
         rdc(odd[i], 32'h0000_0000);
      end
      touch_on <= 1'b1;
      tag_req <= 1'b1;
      remote_ready <= 1'b1;
      repeat (3) @(posedge pclk);
      rdc(8'h1C, 32'h0000_08A0);
      touch_on <= 1'b0;
      tag_req <= 1'b0;
      remote_ready <= 1'b0;
      // display: done stands while monitoring is still requested
      wr(8'h44, 32'h0000_0001);
      pls(0);
      rdc(8'h1C, 32'h0000_0001);
      wr(8'h44, 32'h0000_0002);
      rdc(8'h1C, 32'h0000_0001);
      wr(8'h44, 32'h0000_0000);
      rdc(8'h1C, 32'h0000_0000);
      // init: ignored without its request
      pls(1);
      rdc(8'h1C, 32'h0000_0000);
      wr(8'h44, 32'h0000_0200);
      pls(1);
      rdc(8'h1C, 32'h0000_0200);
      wr(8'h44, 32'h0000_0000);
      rdc(8'h1C, 32'h0000_0000);
      // codes 00 to 23, defined or not, then error reset
      for (int c = 0; c < 8'h24; c++) begin
         ok = (c >= 1 && c <= 9) || (c >= 8'h14 && c <= 8'h21);
         err_code <= 8'(c);
         pls(2);
         rdc(8'h50, ok ? 32'(c) : 32'h0000_D200);
         rdc(8'h1C, ok ? 32'h0000_0401 : 32'h0000_0000);
         chk({31'h0, err_active}, {31'h0, ok});
         chk({24'h00_0000, ecode}, ok ? 32'(c) : 32'h0000_0000);
         wr(8'h44, 32'h0000_0400);
         wr(8'h44, 32'h0000_0000);
         rdc(8'h1C, 32'h0000_0000);
         rdc(8'h50, 32'h0000_D200);
         chk({24'h00_0000, ecode}, 32'h0000_0000);
      end
      report_and_stop();
   end

   // watchdog against a missing pready
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      report_and_stop();
   end
endmodule : rsh_bench
